//--- logic/serial_line_frame.sv
// What this block does
// - Serial mode: bit 0 clear gates on CTS, bit 1 set needs addressing.
// - Modes 0 and 2: no character starts until clear-to-send is asserted.
// - Modes 1 and 3: clear-to-send ignored, characters leave at once.
// - Held-off output queues and stalls the issuing program via ready.
// - Modes 0 and 1: act on every command, reply as required.
// - Modes 2 and 3: ignore commands until a select matches the card.
// - Card number comes from the hardware strap inputs.
// - Handshake 0: no ack for valid, bell for invalid, lines as data CR.
// - Handshake 1: LF acknowledges, bell rejects, lines lead with LF.
// - Handshake 2: ACK acknowledges, bell rejects, lines as data CR.
// - Handshake 3: ACK acknowledges, bell rejects, lines as LF data CR.
// - Trailing ack follows host responses except valid ones in handshake 0, omitted for program messages.
// - Checksum enabled: checksum bytes follow each CR and each valid host response, none after bell.
// - Line handshake setting resets to 1.
// - Dual-port ASCII enable coerces handshake 1 to 0 and 3 to 2.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`default_nettype none
module serial_line_frame
    import line_handshake_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // Register port
    input wire logic [REG_ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [REG_DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [REG_DATA_W-1:0] REG_RDATA_OUT,
    // Pins
    input wire logic HOST_CTS_IN,
    input wire logic [CARD_W-1:0] CARD_STRAP_IN,
    // Card-select command from the command parser
    input wire logic SEL_VALID_IN,
    input wire logic [CARD_W-1:0] SEL_CARD_IN,
    // Outgoing request stream
    input wire logic REQ_VALID_IN,
    output logic REQ_READY_OUT,
    input wire logic REQ_END_IN,
    input wire logic REQ_PROG_IN,
    input wire logic REQ_OK_IN,
    input wire logic REQ_FIRST_IN,
    input wire logic REQ_LAST_IN,
    input wire logic [CHAR_W-1:0] REQ_DATA_IN,
    // Commands may be acted on
    output logic CMD_ENABLE_OUT,
    // Character stream to the serial transmitter
    output logic [CHAR_W-1:0] TX_DATA_OUT,
    output logic TX_VALID_OUT,
    input wire logic TX_READY_IN
);
    // Settings
    logic [1:0] serial_mode_q;
    logic [1:0] line_hs_q;
    logic [1:0] integrity_q;
    logic dual_port_q;
    logic [1:0] hs_eff;
    logic cks_en;
    // Pin synchronisers
    logic [SYNC_STAGES-1:0] cts_sync_q;
    logic [CARD_W-1:0] strap_s1_q;
    logic [CARD_W-1:0] strap_s2_q;
    logic [1:0] strap_wait_q;
    logic [CARD_W-1:0] card_q;
    logic selected_q;
    logic muted;
    // Formatter
    fmt_state_t state_q;
    fmt_state_t state_d;
    logic req_take;
    logic [CHAR_W-1:0] req_data_q;
    logic req_last_q;
    logic [CHAR_W-1:0] ack_char_q;
    logic sum_after_ack_q;
    logic [CHAR_W-1:0] line_sum_q;
    logic [CHAR_W-1:0] emit_char;
    logic emit_valid;
    logic emit_push;
    // Buffer and output stage
    logic buf_in_ready;
    logic [CHAR_W-1:0] buf_data;
    logic buf_valid;
    logic cts_ok;
    logic tx_pop;

    // Dual-port channel drops the leading line feed
    // handshake coercion
    assign hs_eff = dual_port_q ? {line_hs_q[1], 1'b0} : line_hs_q;
    assign cks_en = integrity_q[0];

    // Register writes
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            serial_mode_q <= SERIAL_MODE_RESET;
            line_hs_q <= LINE_HS_RESET;
            integrity_q <= INTEGRITY_RESET;
            dual_port_q <= DUAL_PORT_RESET;
        end else if (REG_WR_IN && REG_ADDR_IN == CTRL_OFFSET) begin
            serial_mode_q <= REG_WDATA_IN[SERIAL_MODE_LSB +: 2];
            line_hs_q <= REG_WDATA_IN[LINE_HS_LSB +: 2];
            integrity_q <= REG_WDATA_IN[INTEGRITY_LSB +: 2];
            dual_port_q <= REG_WDATA_IN[DUAL_PORT_BIT];
        end
    end

    // Register reads, data one cycle after the strobe, zero when unmapped
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            REG_RDATA_OUT <= 16'h0000;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= 16'h0000;
            if (REG_ADDR_IN == CTRL_OFFSET) begin
                REG_RDATA_OUT[SERIAL_MODE_LSB +: 2] <= serial_mode_q;
                REG_RDATA_OUT[LINE_HS_LSB +: 2] <= line_hs_q;
                REG_RDATA_OUT[INTEGRITY_LSB +: 2] <= integrity_q;
                REG_RDATA_OUT[DUAL_PORT_BIT] <= dual_port_q;
            end else if (REG_ADDR_IN == STATUS_OFFSET) begin
                REG_RDATA_OUT[ST_SELECTED_BIT] <= selected_q;
                REG_RDATA_OUT[ST_TX_HELD_BIT] <= buf_valid && !cts_ok;
                REG_RDATA_OUT[ST_REQ_STALL_BIT] <= REQ_VALID_IN
                    && !REQ_READY_OUT;
                REG_RDATA_OUT[ST_CARD_LSB +: CARD_W] <= card_q;
                REG_RDATA_OUT[ST_HS_EFF_LSB +: 2] <= hs_eff;
            end
        end else begin
            REG_RDATA_OUT <= 16'h0000;
        end
    end

    // CTS pin synchroniser; only the last stage is looked at
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            cts_sync_q <= '0;
        end else begin
            cts_sync_q <= {cts_sync_q[SYNC_STAGES-2:0], HOST_CTS_IN};
        end
    end

    // Strap synchroniser
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            strap_s1_q <= '0;
            strap_s2_q <= '0;
        end else begin
            strap_s1_q <= CARD_STRAP_IN;
            strap_s2_q <= strap_s1_q;
        end
    end

    // Card number caught after release, once the synchroniser has filled
    // card number from straps
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            strap_wait_q <= STRAP_SETTLE_CYCLES;
            card_q <= '0;
        end else if (strap_wait_q != 2'h0) begin
            strap_wait_q <= strap_wait_q - 2'h1;
            card_q <= strap_s2_q;
        end
    end

    // Select tracking; a non-matching select silences this card in modes 2 and 3
    // address match
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            selected_q <= 1'b0;
        end else if (SEL_VALID_IN) begin
            selected_q <= (SEL_CARD_IN == card_q);
        end
    end

    assign muted = serial_mode_q[1] && !selected_q;

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            CMD_ENABLE_OUT <= 1'b0;
        end else begin
            CMD_ENABLE_OUT <= !muted;
        end
    end

    assign req_take = REQ_VALID_IN && REQ_READY_OUT;

    // Next state of the line formatter
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (req_take && !(muted && !REQ_PROG_IN)) begin
                    if (!REQ_END_IN) begin
                        // lead LF in handshakes 1 and 3
                        state_d = (REQ_FIRST_IN && hs_eff[0]) ? S_LEAD
                            : S_DATA;
                    end else if (REQ_PROG_IN) begin
                        state_d = S_IDLE;
                    end else if (!REQ_OK_IN || hs_eff != 2'h0) begin
                        state_d = S_ACK;
                    end else if (cks_en) begin
                        state_d = S_CSUM;
                    end
                end
            end
            S_LEAD: if (buf_in_ready) state_d = S_DATA;
            S_DATA: begin
                if (buf_in_ready) begin
                    state_d = req_last_q ? S_CR : S_IDLE;
                end
            end
            S_CR: begin
                if (buf_in_ready) begin
                    state_d = cks_en ? S_LSUM : S_IDLE;
                end
            end
            S_LSUM: if (buf_in_ready) state_d = S_IDLE;
            S_ACK: begin
                if (buf_in_ready) begin
                    state_d = sum_after_ack_q ? S_CSUM : S_IDLE;
                end
            end
            S_CSUM: if (buf_in_ready) state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    // Ready is high only in idle, so held-off output stalls the source
    // stall the issuer
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state_q <= S_IDLE;
            REQ_READY_OUT <= 1'b0;
        end else begin
            state_q <= state_d;
            REQ_READY_OUT <= (state_d == S_IDLE);
        end
    end

    // Request capture and acknowledge choice
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            req_data_q <= '0;
            req_last_q <= 1'b0;
            ack_char_q <= CHAR_BELL;
            sum_after_ack_q <= 1'b0;
        end else if (req_take && state_q == S_IDLE) begin
            req_data_q <= REQ_DATA_IN;
            req_last_q <= REQ_LAST_IN;
            if (!REQ_OK_IN) begin
                ack_char_q <= CHAR_BELL;
            end else if (hs_eff == 2'h1) begin
                ack_char_q <= CHAR_LF;
            end else begin
                ack_char_q <= CHAR_ACK;
            end
            // A rejected line gets no checksum byte
            sum_after_ack_q <= cks_en && REQ_OK_IN;
        end
    end

    // Character offered to the buffer in each state
    always_comb begin
        emit_valid = 1'b1;
        emit_char = CHAR_LF;
        unique case (state_q)
            S_IDLE: emit_valid = 1'b0;
            S_LEAD: emit_char = CHAR_LF;
            S_DATA: emit_char = req_data_q;
            S_CR: emit_char = CHAR_CR;
            S_LSUM: emit_char = line_sum_q;
            S_ACK: emit_char = ack_char_q;
            S_CSUM: emit_char = req_data_q;
            default: emit_valid = 1'b0;
        endcase
    end

    assign emit_push = emit_valid && buf_in_ready;

    // Running line checksum, control characters included
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            line_sum_q <= '0;
        end else if (state_q == S_IDLE && req_take && REQ_FIRST_IN) begin
            line_sum_q <= '0;
        end else if (emit_push && (state_q == S_LEAD || state_q == S_DATA
                || state_q == S_CR)) begin
            line_sum_q <= line_sum_q + emit_char;
        end
    end

    // Two entries decouple the formatter from a stalled transmitter
    two_entry_buffer #(
        .WIDTH(CHAR_W)
    ) u_tx_buffer (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .in_data_in(emit_char),
        .in_valid_in(emit_valid),
        .in_ready_out(buf_in_ready),
        .out_data_out(buf_data),
        .out_valid_out(buf_valid),
        .out_ready_in(tx_pop)
    );

    assign cts_ok = serial_mode_q[0] || cts_sync_q[SYNC_STAGES-1];
    assign tx_pop = buf_valid && cts_ok && (!TX_VALID_OUT || TX_READY_IN);

    // Output stage; a character once offered is not withdrawn by CTS
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            TX_VALID_OUT <= 1'b0;
            TX_DATA_OUT <= '0;
        end else if (tx_pop) begin
            TX_VALID_OUT <= 1'b1;
            TX_DATA_OUT <= buf_data;
        end else if (TX_READY_IN) begin
            TX_VALID_OUT <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- logic/line_handshake_pkg.sv
`default_nettype none
package line_handshake_pkg;
    // Register map, word offsets on the plain register port
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h1;
    // Control field positions
    localparam int SERIAL_MODE_LSB = 0;
    localparam int LINE_HS_LSB = 2;
    localparam int INTEGRITY_LSB = 4;
    localparam int DUAL_PORT_BIT = 6;
    // Status field positions
    localparam int ST_SELECTED_BIT = 0;
    localparam int ST_TX_HELD_BIT = 1;
    localparam int ST_REQ_STALL_BIT = 2;
    localparam int ST_CARD_LSB = 4;
    localparam int ST_HS_EFF_LSB = 8;
    // Reset values of the settings
    localparam logic [1:0] SERIAL_MODE_RESET = 2'h0;
    localparam logic [1:0] LINE_HS_RESET = 2'h1;
    localparam logic [1:0] INTEGRITY_RESET = 2'h0;
    localparam logic DUAL_PORT_RESET = 1'b0;
    // Framing characters
    localparam logic [7:0] CHAR_LF = 8'h0a;
    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [7:0] CHAR_ACK = 8'h06;
    localparam logic [7:0] CHAR_BELL = 8'h07;
    // Widths
    localparam int CHAR_W = 8;
    localparam int CARD_W = 4;
    localparam int REG_ADDR_W = 4;
    localparam int REG_DATA_W = 16;
    // Cycles after reset release before the card strap is latched
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;
    // Formatter states
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_LEAD = 7'h02,
        S_DATA = 7'h04,
        S_CR = 7'h08,
        S_LSUM = 7'h10,
        S_ACK = 7'h20,
        S_CSUM = 7'h40
    } fmt_state_t;
endpackage
`default_nettype wire

//--- logic/two_entry_buffer.sv
`default_nettype none
module two_entry_buffer #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    logic [WIDTH-1:0] slot_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    // Honest full and empty from the entry count
    assign in_ready_out = (count_q != 2'h2);
    assign out_valid_out = (count_q != 2'h0);
    assign out_data_out = slot_q[rd_ptr_q];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Storage, written at the write pointer
    always_ff @(posedge clk_in) begin
        if (push) begin
            slot_q[wr_ptr_q] <= in_data_in;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/line_frame_monitor.sv
`default_nettype none
module line_frame_monitor
    import line_handshake_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [REG_ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [REG_DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [REG_DATA_W-1:0] REG_RDATA_OUT,
    input wire logic HOST_CTS_IN,
    input wire logic [CARD_W-1:0] CARD_STRAP_IN,
    input wire logic SEL_VALID_IN,
    input wire logic [CARD_W-1:0] SEL_CARD_IN,
    input wire logic REQ_VALID_IN,
    input wire logic REQ_READY_OUT,
    input wire logic REQ_END_IN,
    input wire logic REQ_PROG_IN,
    input wire logic REQ_OK_IN,
    input wire logic CMD_ENABLE_OUT,
    input wire logic [CHAR_W-1:0] TX_DATA_OUT,
    input wire logic TX_VALID_OUT,
    input wire logic TX_READY_IN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] mode_q;
    logic take;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Shadow of the serial mode, tracks control writes
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            mode_q <= SERIAL_MODE_RESET;
        end else if (REG_WR_IN && REG_ADDR_IN == CTRL_OFFSET) begin
            mode_q <= REG_WDATA_IN[SERIAL_MODE_LSB +: 2];
        end
    end
    // Request accepted this edge
    assign take = REQ_VALID_IN && REQ_READY_OUT;
    chk_rdata_quiet: assert property (
        !$past(REG_RD_IN) |-> REG_RDATA_OUT == 16'h0000)
        else $error("read data outside its slot");
    chk_reset_ready: assert property (
        $fell(SYS_RST_IN) |=> REQ_READY_OUT && CMD_ENABLE_OUT)
        else $error("not ready after reset");
    chk_tx_hold: assert property (
        TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
        else $error("offered character dropped");
    chk_cts_gate: assert property (
        (!mode_q[0] && !HOST_CTS_IN) [*4] ##0 !TX_VALID_OUT |=> !TX_VALID_OUT)
        else $error("character started without clear to send");
    chk_addr_free: assert property (
        !mode_q[1] [*3] |-> CMD_ENABLE_OUT)
        else $error("muted without addressing");
    chk_select_match: assert property (
        SEL_VALID_IN && mode_q[1] |-> ##2
        CMD_ENABLE_OUT == ($past(SEL_CARD_IN, 2) == CARD_STRAP_IN))
        else $error("select result wrong");
    chk_data_stalls: assert property (
        take && !REQ_END_IN && (CMD_ENABLE_OUT || REQ_PROG_IN)
        |=> !REQ_READY_OUT)
        else $error("data request did not stall");
    chk_bell_sent: assert property (
        take && REQ_END_IN && !REQ_OK_IN && !REQ_PROG_IN && CMD_ENABLE_OUT
        |=> !REQ_READY_OUT)
        else $error("invalid command gave no reply");
    chk_muted_drop: assert property (
        take && !REQ_PROG_IN && !CMD_ENABLE_OUT |=> REQ_READY_OUT)
        else $error("muted host request emitted");
    chk_prog_end: assert property (
        take && REQ_END_IN && REQ_PROG_IN |=> REQ_READY_OUT)
        else $error("program message got an ack");
endmodule
`default_nettype wire

//--- tb/host_link_model.sv
`default_nettype none
module host_link_model
    import line_handshake_pkg::*;
(
    input wire logic clk_in,
    input wire logic [CHAR_W-1:0] tx_data_in,
    input wire logic tx_valid_in,
    input wire logic slow_in,
    input wire logic hold_in,
    output logic tx_ready_out,
    output logic cts_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [CHAR_W-1:0] rx_q[$];
    logic phase_q;
    // Known levels before the first edge
    initial begin
        tx_ready_out = 1'h0;
        cts_out = 1'h0;
        phase_q = 1'h0;
    end
    always @(posedge clk_in) begin
        cts_out <= !hold_in;
    end
    // Slow host takes a char every other cycle, to stress the buffer
    always @(posedge clk_in) begin
        phase_q <= !phase_q;
        tx_ready_out <= !slow_in || phase_q;
        if (tx_valid_in && tx_ready_out) begin
            rx_q.push_back(tx_data_in);
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`default_nettype none
module testbench import line_handshake_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] STRAP = 4'h9;
    // Request flags: end, prog, ok, first, last
    localparam logic [4:0] L_HOST = 5'h03, L_PROG = 5'h0b;
    localparam logic [4:0] E_OK = 5'h14, E_BAD = 5'h10, E_PROG = 5'h1c;
    logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0;
    logic [3:0] addr = 4'h0, sel_c = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic sel_v = 1'h0, req_v = 1'h0, ready, cmd_en, tx_v, tx_rdy, cts;
    logic [4:0] req_f = 5'h00;
    logic [7:0] req_d = 8'h00, tx_d;
    logic slow = 1'h0, hold = 1'h0;
    logic [7:0] e[$];
    int n_fail = 0, total_checks = 0;
    serial_line_frame i_dut (
        .CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_RDATA_OUT(rdata), .HOST_CTS_IN(cts), .CARD_STRAP_IN(STRAP),
        .SEL_VALID_IN(sel_v), .SEL_CARD_IN(sel_c), .REQ_VALID_IN(req_v),
        .REQ_READY_OUT(ready), .REQ_END_IN(req_f[4]),
        .REQ_PROG_IN(req_f[3]), .REQ_OK_IN(req_f[2]),
        .REQ_FIRST_IN(req_f[1]), .REQ_LAST_IN(req_f[0]),
        .REQ_DATA_IN(req_d), .CMD_ENABLE_OUT(cmd_en), .TX_DATA_OUT(tx_d),
        .TX_VALID_OUT(tx_v), .TX_READY_IN(tx_rdy));
    host_link_model i_host (
        .clk_in(clk), .tx_data_in(tx_d), .tx_valid_in(tx_v),
        .slow_in(slow), .hold_in(hold), .tx_ready_out(tx_rdy),
        .cts_out(cts));
    // 10 MHz clock
    always #50 clk = ~clk;
    task automatic chk(input string nm, input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        @(posedge clk);
        d = rdata;
    endtask
    // Offer a request and hold it until taken; hang ends the run
    task automatic req(input logic [4:0] f, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req_v <= 1'h1;
        req_f <= f;
        req_d <= d;
        do begin
            @(posedge clk);
            n++;
        end while (!ready && n < 300);
        req_v <= 1'h0;
        if (!ready) begin
            chk("request taken", 16'h0, 16'h1);
            report_and_stop();
        end
    endtask
    task automatic sel(input logic [3:0] c);
        @(posedge clk);
        sel_v <= 1'h1;
        sel_c <= c;
        @(posedge clk);
        sel_v <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    // Compare what the host received against the expected queue
    task automatic expect_rx();
        int n;
        n = 0;
        while (i_host.rx_q.size() < e.size() && n < 400) begin
            @(posedge clk);
            n++;
        end
        repeat (10) @(posedge clk);
        chk("rx count", 16'(i_host.rx_q.size()), 16'(e.size()));
        foreach (e[i]) begin
            if (i < i_host.rx_q.size()) begin
                chk("rx char", 16'(i_host.rx_q[i]), 16'(e[i]));
            end
        end
        e.delete();
        i_host.rx_q.delete();
        if (n >= 400) report_and_stop();
    endtask
    task automatic t_regs();
        logic [15:0] d;
        rd_reg(CTRL_OFFSET, d);
        chk("ctrl reset", d, 16'h0004);
        wr_reg(4'hf, 16'hffff);
        rd_reg(4'hf, d);
        chk("unmapped read", d, 16'h0000);
        wr_reg(CTRL_OFFSET, 16'h0047);
        rd_reg(CTRL_OFFSET, d);
        chk("ctrl readback", d, 16'h0047);
        rd_reg(STATUS_OFFSET, d);
        chk("card", {12'h0, d[ST_CARD_LSB +: 4]}, {12'h0, STRAP});
        chk("eff hs", {14'h0, d[ST_HS_EFF_LSB +: 2]}, 16'h0);
        wr_reg(CTRL_OFFSET, 16'h0004);
        $display("test regs done");
    endtask
    // Every handshake mode, dual-port coercion, slow host on odd passes
    task automatic t_frames();
        logic [15:0] d;
        logic [1:0] h;
        logic dp;
        for (int i = 0; i < 6; i++) begin
            dp = (i >= 4);
            h = (i < 4) ? 2'(i) : 2'(2 * i - 7);
            slow <= i[0];
            wr_reg(CTRL_OFFSET, {9'h0, dp, 2'h0, h, 2'h0});
            rd_reg(STATUS_OFFSET, d);
            if (dp) h[0] = 1'h0;
            chk("eff hs", 16'(d[ST_HS_EFF_LSB +: 2]), 16'(h));
            req(L_HOST, 8'h41);
            req(E_OK, 8'h00);
            req(E_BAD, 8'h00);
            req(L_PROG, 8'h50);
            req(E_PROG, 8'h00);
            for (int k = 0; k < 2; k++) begin
                if (h[0]) e.push_back(CHAR_LF);
                e.push_back(k ? 8'h50 : 8'h41);
                e.push_back(CHAR_CR);
                if (k == 0 && h != 2'h0) begin
                    e.push_back(h == 2'h1 ? CHAR_LF : CHAR_ACK);
                end
                if (k == 0) e.push_back(CHAR_BELL);
            end
            expect_rx();
        end
        slow <= 1'h0;
        $display("test frames done");
    endtask
    task automatic t_checksum();
        wr_reg(CTRL_OFFSET, 16'h0018);
        req(L_HOST, 8'h41);
        req(E_OK, 8'h5a);
        req(E_BAD, 8'h33);
        e = '{8'h41, CHAR_CR, 8'(8'h41 + CHAR_CR), CHAR_ACK,
            8'h5a, CHAR_BELL};
        expect_rx();
        $display("test checksum done");
    endtask
    task automatic t_cts();
        logic [15:0] d;
        wr_reg(CTRL_OFFSET, 16'h0004);
        hold <= 1'h1;
        repeat (4) @(posedge clk);
        req(L_HOST, 8'h42);
        repeat (30) @(posedge clk);
        rd_reg(STATUS_OFFSET, d);
        chk("held status", 16'(d[ST_TX_HELD_BIT]), 16'h1);
        chk("tx held", {15'h0, tx_v}, 16'h0);
        chk("request stalled", {15'h0, ready}, 16'h0);
        hold <= 1'h0;
        req(E_OK, 8'h00);
        e = '{CHAR_LF, 8'h42, CHAR_CR, CHAR_LF};
        expect_rx();
        wr_reg(CTRL_OFFSET, 16'h0005);
        hold <= 1'h1;
        req(L_HOST, 8'h43);
        req(E_OK, 8'h00);
        e = '{CHAR_LF, 8'h43, CHAR_CR, CHAR_LF};
        expect_rx();
        hold <= 1'h0;
        $display("test cts done");
    endtask
    task automatic t_addr();
        logic [15:0] d;
        wr_reg(CTRL_OFFSET, 16'h0006);
        sel(STRAP);
        sel(STRAP ^ 4'h1);
        chk("enable wrong card", {15'h0, cmd_en}, 16'h0);
        req(L_HOST, 8'h48);
        req(E_OK, 8'h00);
        req(L_PROG, 8'h51);
        req(E_PROG, 8'h00);
        e = '{CHAR_LF, 8'h51, CHAR_CR};
        expect_rx();
        sel(STRAP);
        chk("enable own card", {15'h0, cmd_en}, 16'h1);
        req(E_OK, 8'h00);
        e = '{CHAR_LF};
        expect_rx();
        rd_reg(STATUS_OFFSET, d);
        chk("selected", {15'h0, d[ST_SELECTED_BIT]}, 16'h1);
        wr_reg(CTRL_OFFSET, 16'h0004);
        $display("test addressing done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        t_regs();
        t_frames();
        t_checksum();
        t_cts();
        t_addr();
        report_and_stop();
    end
endmodule
bind serial_line_frame line_frame_monitor i_mon (
    .CLK_IN, .SYS_RST_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN,
    .REG_RD_IN, .REG_RDATA_OUT, .HOST_CTS_IN, .CARD_STRAP_IN,
    .SEL_VALID_IN, .SEL_CARD_IN, .REQ_VALID_IN, .REQ_READY_OUT,
    .REQ_END_IN, .REQ_PROG_IN, .REQ_OK_IN, .CMD_ENABLE_OUT,
    .TX_DATA_OUT, .TX_VALID_OUT, .TX_READY_IN);
`default_nettype wire
